/* pkg/bcs_pkg.sv */
package bcs_pkg;
  localparam logic [7:0] BCS_ADDR_BYTE2 = 8'h4d;
  localparam logic [7:0] BCS_ADDR_BYTE3 = 8'h4e;
  localparam logic [7:0] BCS_ADDR_CTL = 8'h4f;
  localparam logic [7:0] BCS_ADDR_STS = 8'h50;
  localparam logic [7:0] BCS_BYTE_RESET = 8'h00;
  localparam int BCS_CTL_SRC_BIT = 4;
  localparam int BCS_CTL_EN_BIT = 3;
  localparam int BCS_CTL_WIPE_BIT = 2;
  localparam int BCS_CTL_RELOAD_BIT = 1;
  localparam int BCS_CTL_BLOCK_BIT = 0;
  localparam int BCS_STS_SUPPLY_BIT = 7;
  localparam int BCS_STS_HDMI_BIT = 6;
  localparam int BCS_STS_CIPHER_BIT = 5;
  localparam int BCS_STS_INIT_BIT = 4;
  localparam int BCS_STS_REMOTE_BIT = 3;
  localparam int BCS_STS_CFG_BIT = 2;
  localparam int BCS_STS_CFGSUM_BIT = 1;
  localparam int BCS_STS_IDSUM_BIT = 0;
  localparam logic [7:0] BCS_STS_RESET = 8'h03;
  localparam int BCS_CFG_SUM_BYTES = 128;
  localparam int BCS_ID_SUM_BYTES = 256;
  localparam longint BCS_CLK_HZ = 50000000;
  localparam longint BCS_INT_SRC_HZ = 50000000;
  localparam longint BCS_EXT_SRC_HZ = 25000000;
  localparam longint BCS_CEC_HZ_X1000 = 32768000;
  typedef enum logic {BCS_SRC_INTERNAL, BCS_SRC_EXTERNAL} bcs_src_type;
endpackage

/* pkg/bcs_cec_if.sv */
`timescale 1ns/1ps
interface bcs_cec_if;
  logic enable;
  logic source;
  logic ext_tick;
  logic cec_tick;
  modport ctl (output enable, output source, output ext_tick, input cec_tick);
  modport gen (input enable, input source, input ext_tick, output cec_tick);
endinterface

/* logic/bcs_cec_gen.sv */
`timescale 1ns/1ps
module bcs_cec_gen
  import bcs_pkg::*;
#(
  parameter int ACC_W = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  bcs_cec_if.gen cec
);
  // fractional accumulator: each source tick adds the output rate
  localparam logic [ACC_W-1:0] INC = ACC_W'(BCS_CEC_HZ_X1000 / 1000);
  localparam logic [ACC_W-1:0] MOD_INT = ACC_W'(BCS_INT_SRC_HZ);
  localparam logic [ACC_W-1:0] MOD_EXT = ACC_W'(BCS_EXT_SRC_HZ);
  logic [ACC_W-1:0] acc_r;
  logic cec_r;
  wire src_tick = (cec.source == BCS_SRC_EXTERNAL) ? cec.ext_tick : 1'b1;
  wire [ACC_W-1:0] modulus = (cec.source == BCS_SRC_EXTERNAL) ? MOD_EXT
                                                                : MOD_INT;
  wire [ACC_W:0] sum = {1'b0, acc_r} + {1'b0, INC};
  wire wrap = sum >= {1'b0, modulus};
  wire [ACC_W-1:0] acc_nxt = wrap ? ACC_W'(sum - {1'b0, modulus})
                                  : sum[ACC_W-1:0];
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r <= '0;
      cec_r <= 1'b0;
    end else if (ce) begin
      if (!cec.enable) begin
        acc_r <= '0;
        cec_r <= 1'b0;
      end else if (src_tick) begin
        acc_r <= acc_nxt;
        cec_r <= wrap;
      end else begin
        cec_r <= 1'b0;
      end
    end
  end
  assign cec.cec_tick = cec_r;
endmodule // bcs_cec_gen

/* logic/bcs_edid_seq.sv */
`timescale 1ns/1ps
module bcs_edid_seq
  import bcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic wipe,
  input wire logic mem_done,
  input wire logic sum_ok,
  output logic mem_start,
  output logic mem_wipe,
  output logic busy,
  output logic finish,
  output logic sum_ok_r
);
  typedef enum logic [1:0] {BCS_IDLE, BCS_ISSUE, BCS_WAIT} bcs_seq_type;
  bcs_seq_type st_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= BCS_IDLE;
      mem_start <= 1'b0;
      mem_wipe <= 1'b0;
      finish <= 1'b0;
      sum_ok_r <= 1'b0;
    end else if (ce) begin
      mem_start <= 1'b0;
      finish <= 1'b0;
      unique case (st_r)
        BCS_IDLE: if (start) begin
          st_r <= BCS_ISSUE;
        end
        BCS_ISSUE: begin
          // wipe rises with the start pulse so the loader sees both at once
          mem_wipe <= wipe;
          mem_start <= 1'b1;
          st_r <= BCS_WAIT;
        end
        BCS_WAIT: if (mem_done) begin
          finish <= 1'b1;
          sum_ok_r <= sum_ok;
          mem_wipe <= 1'b0;
          st_r <= BCS_IDLE;
        end
        default: st_r <= BCS_IDLE;
      endcase
    end
  end
  assign busy = st_r != BCS_IDLE;
endmodule // bcs_edid_seq

/* logic/bcs_regs.sv */
`timescale 1ns/1ps
// How it works
// - two RW window bytes, reset zero
// - CEC source bit picks internal or 25MHz
// - CEC clock runs only when enabled
// - wipe needs reload; cleared on finish
// - reload bit starts reload, self-clears
// - strap-latched DDC block bit, read-only
// - status bit 7 shows receiver supply
// - status bit 6 shows HDMI interrupt
// - status bit 5 shows cipher interrupt
// - init done only after config done
// - status bit 2 marks config done
// - status bit 3 marks remote load
// - config checksum result in bit 1
// - ID checksum result in bit 0
// - APB read result fills window bytes
module bcs_regs
  import bcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic apb_rd_done,
  input wire logic [15:0] apb_rd_upper,
  input wire logic strap_pin_zero,
  input wire logic receiver_supply_input,
  input wire logic hdmi_irq_pending,
  input wire logic cipher_tx_irq_pending,
  input wire logic cfg_seq_done,
  input wire logic cfg_sum_pass,
  input wire logic init_seq_done,
  input wire logic remote_load_done,
  input wire logic remote_sum_pass,
  input wire logic ext_osc_tick,
  input wire logic edid_mem_done,
  input wire logic edid_sum_pass,
  output logic [7:0] window_data_byte_two,
  output logic [7:0] window_data_byte_three,
  output logic cec_tick_out,
  output logic edid_mem_start,
  output logic edid_mem_wipe,
  output logic display_id_ddc_block
);
  logic [7:0] byte2_r;
  logic [7:0] byte3_r;
  logic src_r;
  logic en_r;
  logic wipe_r;
  logic reload_r;
  logic block_r;
  logic strap_taken_r;
  logic supply_r;
  logic hdmi_r;
  logic cipher_r;
  logic cfg_done_r;
  logic init_done_r;
  logic remote_r;
  logic cfgsum_r;
  logic idsum_r;
  logic [7:0] rdata_r;
  logic cec_out_r;
  logic mem_start_r;
  logic mem_wipe_r;
  logic seq_start;
  logic seq_busy;
  logic seq_finish;
  logic seq_sum;
  logic seq_mem_start;
  logic seq_mem_wipe;

  wire wr_b2 = reg_wr && reg_addr == BCS_ADDR_BYTE2;
  wire wr_b3 = reg_wr && reg_addr == BCS_ADDR_BYTE3;
  wire wr_ctl = reg_wr && reg_addr == BCS_ADDR_CTL;
  wire wr_reload = wr_ctl && reg_wdata[BCS_CTL_RELOAD_BIT];
  wire [7:0] ctl_view = {3'h0, src_r, en_r, wipe_r, reload_r, block_r};
  wire [7:0] sts_view = {supply_r, hdmi_r, cipher_r, init_done_r,
                         remote_r, cfg_done_r, cfgsum_r, idsum_r};
  wire [7:0] rd_mux = (reg_addr == BCS_ADDR_BYTE2) ? byte2_r :
                      (reg_addr == BCS_ADDR_BYTE3) ? byte3_r :
                      (reg_addr == BCS_ADDR_CTL) ? ctl_view :
                      (reg_addr == BCS_ADDR_STS) ? sts_view : 8'h00;
  assign seq_start = reload_r && !seq_busy && !seq_finish;

  bcs_cec_if cec_bus ();
  assign cec_bus.enable = en_r;
  assign cec_bus.source = src_r;
  assign cec_bus.ext_tick = ext_osc_tick;

  bcs_cec_gen #(.ACC_W(32)) u_cec (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .cec(cec_bus.gen)
  );

  bcs_edid_seq u_seq (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .start(seq_start),
    .wipe(wipe_r),
    .mem_done(edid_mem_done),
    .sum_ok(edid_sum_pass),
    .mem_start(seq_mem_start),
    .mem_wipe(seq_mem_wipe),
    .busy(seq_busy),
    .finish(seq_finish),
    .sum_ok_r(seq_sum)
  );

  // window bytes: host write, or captured from an APB read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      byte2_r <= BCS_BYTE_RESET;
      byte3_r <= BCS_BYTE_RESET;
    end else if (ce) begin
      if (apb_rd_done) begin
        byte2_r <= apb_rd_upper[7:0];
        byte3_r <= apb_rd_upper[15:8];
      end else begin
        if (wr_b2) begin
          byte2_r <= reg_wdata;
        end
        if (wr_b3) begin
          byte3_r <= reg_wdata;
        end
      end
    end
  end

  // control: reload and wipe self-clear when the sequence finishes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      src_r <= 1'b0;
      en_r <= 1'b0;
      wipe_r <= 1'b0;
      reload_r <= 1'b0;
    end else if (ce) begin
      if (wr_ctl) begin
        src_r <= reg_wdata[BCS_CTL_SRC_BIT];
        en_r <= reg_wdata[BCS_CTL_EN_BIT];
      end
      if (wr_reload && !reload_r) begin
        reload_r <= 1'b1;
        wipe_r <= reg_wdata[BCS_CTL_WIPE_BIT];
      end else if (seq_finish) begin
        reload_r <= 1'b0;
        wipe_r <= 1'b0;
      end
    end
  end

  // strap caught on the first enabled edge after reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      block_r <= 1'b0;
      strap_taken_r <= 1'b0;
    end else if (ce && !strap_taken_r) begin
      block_r <= strap_pin_zero;
      strap_taken_r <= 1'b1;
    end
  end

  // status: register inputs; host writes to it have no effect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      supply_r <= BCS_STS_RESET[BCS_STS_SUPPLY_BIT];
      hdmi_r <= BCS_STS_RESET[BCS_STS_HDMI_BIT];
      cipher_r <= BCS_STS_RESET[BCS_STS_CIPHER_BIT];
      init_done_r <= BCS_STS_RESET[BCS_STS_INIT_BIT];
      remote_r <= BCS_STS_RESET[BCS_STS_REMOTE_BIT];
      cfg_done_r <= BCS_STS_RESET[BCS_STS_CFG_BIT];
      cfgsum_r <= BCS_STS_RESET[BCS_STS_CFGSUM_BIT];
      idsum_r <= BCS_STS_RESET[BCS_STS_IDSUM_BIT];
    end else if (ce) begin
      supply_r <= receiver_supply_input;
      hdmi_r <= hdmi_irq_pending;
      cipher_r <= cipher_tx_irq_pending;
      if (cfg_seq_done) begin
        cfg_done_r <= 1'b1;
        cfgsum_r <= cfg_sum_pass;
      end
      if (init_seq_done && cfg_done_r) begin
        init_done_r <= 1'b1;
      end
      if (remote_load_done) begin
        remote_r <= 1'b1;
        idsum_r <= remote_sum_pass;
      end else if (seq_finish) begin
        idsum_r <= seq_sum;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
      cec_out_r <= 1'b0;
      mem_start_r <= 1'b0;
      mem_wipe_r <= 1'b0;
    end else if (ce) begin
      if (reg_rd) begin
        rdata_r <= rd_mux;
      end
      cec_out_r <= cec_bus.cec_tick;
      mem_start_r <= seq_mem_start;
      mem_wipe_r <= seq_mem_wipe;
    end
  end

  assign reg_rdata = rdata_r;
  assign window_data_byte_two = byte2_r;
  assign window_data_byte_three = byte3_r;
  assign cec_tick_out = cec_out_r;
  assign edid_mem_start = mem_start_r;
  assign edid_mem_wipe = mem_wipe_r;
  assign display_id_ddc_block = block_r;
endmodule // bcs_regs

/* dv/bcs_regs_asserts.sv */
`timescale 1ns/1ps
module bcs_regs_asserts
  import bcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic apb_rd_done,
  input wire logic [15:0] apb_rd_upper,
  input wire logic edid_mem_done,
  input wire logic [7:0] window_data_byte_two,
  input wire logic [7:0] window_data_byte_three,
  input wire logic cec_tick_out,
  input wire logic edid_mem_start,
  input wire logic edid_mem_wipe,
  input wire logic display_id_ddc_block
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic en_r;
  logic [1:0] up_cnt;
  // shadow of the timebase enable and a count of enabled edges since reset that stops at 3
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_r <= 1'b0;
      up_cnt <= 2'h0;
    end else if (ce) begin
      if (reg_wr && reg_addr == BCS_ADDR_CTL) en_r <= reg_wdata[BCS_CTL_EN_BIT];
      if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
    end
  end
  a_apb_fill: assert property (ce && apb_rd_done |=>
    {window_data_byte_three, window_data_byte_two} == $past(apb_rd_upper))
    else $error("window bytes not loaded from read result");
  a_byte_write: assert property (ce && reg_wr && !apb_rd_done &&
    reg_addr == BCS_ADDR_BYTE2 |=> window_data_byte_two == $past(reg_wdata))
    else $error("window byte two write lost");
  a_strap_hold: assert property (up_cnt == 2'h3 |->
    $stable(display_id_ddc_block)) else $error("ddc block bit moved");
  a_start_pulse: assert property (edid_mem_start |=> !edid_mem_start)
    else $error("reload start longer than one cycle");
  a_cec_off: assert property ((!en_r) [*4] |-> !cec_tick_out)
    else $error("timebase tick while disabled");
  a_cec_single: assert property (cec_tick_out |=> !cec_tick_out)
    else $error("timebase tick too long");
  a_wipe_start: assert property ($rose(edid_mem_wipe) |-> edid_mem_start)
    else $error("wipe raised without start");
  a_wipe_clear: assert property (ce && edid_mem_done && edid_mem_wipe
    |-> ##[1:3] !edid_mem_wipe) else $error("wipe not cleared");
  a_unmapped_zero: assert property (ce && reg_rd && reg_addr == 8'h51
    |-> ##1 reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule // bcs_regs_asserts
bind bcs_regs bcs_regs_asserts u_asserts (.*);

/* dv/bcs_mem_model.sv */
`timescale 1ns/1ps
module bcs_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [3:0] dly,
  input wire logic pass_in,
  output logic done,
  output logic pass
);
  logic [3:0] cnt_r;
  // result line is only meaningful with done, so it wanders otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      done <= 1'b0;
      pass <= 1'b0;
    end else begin
      done <= cnt_r == 4'h1;
      pass <= cnt_r == 4'h1 ? pass_in : ~pass;
      if (start) cnt_r <= dly;
      else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
    end
  end
endmodule // bcs_mem_model

/* dv/bcs_regs_tb_top.sv */
`timescale 1ns/1ps
module bcs_regs_tb_top;
  import bcs_pkg::*;
  logic clk, rst, ce, reg_wr, reg_rd, apb_rd_done, strap_pin_zero;
  logic receiver_supply_input, hdmi_irq_pending, cipher_tx_irq_pending;
  logic cfg_seq_done, cfg_sum_pass, init_seq_done, remote_load_done;
  logic remote_sum_pass, ext_osc_tick, edid_mem_done, edid_sum_pass;
  logic cec_tick_out, edid_mem_start, edid_mem_wipe, display_id_ddc_block;
  logic mem_pass, wipe_seen;
  logic [3:0] mem_dly;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [7:0] window_data_byte_two, window_data_byte_three;
  logic [15:0] apb_rd_upper;
  logic [31:0] seed = 32'hb08e;
  int miscompares, cmp_count, ticks, starts;
  bcs_regs u_dut (.*);
  bcs_mem_model u_mem (.clk(clk), .rst(rst), .start(edid_mem_start),
    .dly(mem_dly), .pass_in(mem_pass), .done(edid_mem_done),
    .pass(edid_sum_pass));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge clk) ext_osc_tick <= ~ext_osc_tick;
  always @(posedge clk) begin
    if (cec_tick_out === 1'b1) ticks++;
    if (edid_mem_start === 1'b1) begin
      starts++;
      wipe_seen <= edid_mem_wipe;
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic final_report;
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, m, e);
    rd(a);
    chk(16'(d & m), 16'(e));
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask
  task automatic reload(input logic [7:0] v, input logic p);
    int n;
    n = starts;
    mem_pass = p;
    seed = xs(seed);
    mem_dly = seed[3:0] | 4'h8;
    wr(BCS_ADDR_CTL, v);
    rc(BCS_ADDR_CTL, 8'h06, v & 8'h06);
    for (int i = 0; i < 20 && d[2:1] != 2'h0; i++) rd(BCS_ADDR_CTL);
    chk(16'(d[2:1]), 16'h0);
    chk(16'(starts - n), 16'h1);
    chk(16'(wipe_seen), 16'(v[2]));
    rc(BCS_ADDR_STS, 8'h01, 8'(p));
  endtask
  task automatic cec(input logic [7:0] v, input int cyc);
    int e;
    wr(BCS_ADDR_CTL, v);
    repeat (4) @(negedge clk);
    ticks = 0;
    repeat (cyc) @(negedge clk);
    e = v[3] ? int'(cyc * BCS_CEC_HZ_X1000 / (BCS_CLK_HZ * 1000)) : 0;
    chk(16'(ticks >= e - int'(v[3]) && ticks <= e + int'(v[3])), 16'h1);
  endtask
  initial begin
    #1000000;
    miscompares++;
    final_report;
  end
  initial begin
    int n;
    {reg_wr, reg_rd, reg_addr, reg_wdata, apb_rd_done, apb_rd_upper} = '0;
    {receiver_supply_input, hdmi_irq_pending, cipher_tx_irq_pending} = '0;
    {cfg_seq_done, init_seq_done, remote_load_done, ext_osc_tick} = '0;
    {cfg_sum_pass, remote_sum_pass, mem_pass, strap_pin_zero, ce} = '1;
    mem_dly = 4'h8;
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    rc(BCS_ADDR_BYTE3, 8'hff, BCS_BYTE_RESET);
    rc(BCS_ADDR_STS, 8'hff, BCS_STS_RESET);
    strap_pin_zero = 1'b0;
    wr(BCS_ADDR_CTL, 8'he0);
    rc(BCS_ADDR_CTL, 8'hff, 8'h01);
    chk(16'(display_id_ddc_block), 16'h1);
    wr(BCS_ADDR_STS, 8'hfc);
    rc(BCS_ADDR_STS, 8'hff, BCS_STS_RESET);
    rc(8'h51, 8'hff, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(BCS_ADDR_BYTE2, seed[7:0]);
      wr(BCS_ADDR_BYTE3, seed[15:8]);
      rc(BCS_ADDR_BYTE2, 8'hff, seed[7:0]);
      rc(BCS_ADDR_BYTE3, 8'hff, seed[15:8]);
      {receiver_supply_input, hdmi_irq_pending} = seed[18:17];
      cipher_tx_irq_pending = seed[16];
      rc(BCS_ADDR_STS, 8'he0, {seed[18:16], 5'h0});
      apb_rd_upper = seed[31:16];
      pulse(apb_rd_done);
      rc(BCS_ADDR_BYTE2, 8'hff, seed[23:16]);
      rc(BCS_ADDR_BYTE3, 8'hff, seed[31:24]);
      chk({window_data_byte_three, window_data_byte_two}, seed[31:16]);
    end
    ce = 1'b0;
    wr(BCS_ADDR_BYTE3, 8'h5a);
    ce = 1'b1;
    rc(BCS_ADDR_BYTE3, 8'hff, seed[31:24]);
    pulse(init_seq_done);
    rc(BCS_ADDR_STS, 8'h10, 8'h00);
    cfg_sum_pass = 1'b0;
    pulse(cfg_seq_done);
    rc(BCS_ADDR_STS, 8'h16, 8'h04);
    pulse(init_seq_done);
    rc(BCS_ADDR_STS, 8'h10, 8'h10);
    remote_sum_pass = 1'b0;
    pulse(remote_load_done);
    rc(BCS_ADDR_STS, 8'h09, 8'h08);
    reload(8'h02, 1'b1);
    reload(8'h06, 1'b0);
    reload(8'h06, 1'b1);
    n = starts;
    wr(BCS_ADDR_CTL, 8'h04);
    rc(BCS_ADDR_CTL, 8'h06, 8'h00);
    chk(16'(starts - n), 16'h0);
    cec(8'h08, 8000);
    cec(8'h18, 8000);
    cec(8'h10, 2000);
    final_report;
  end
endmodule // bcs_regs_tb_top
